/* File: inc/uoeb_pkg.sv */
// Package for the OTG event flag and bus control register slice.
// Assumes a 32-bit APB slave with word-aligned byte addresses.
package uoeb_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [11:0] OFS_OTG_EVENT_FLAGS       = 12'h004;
  localparam logic [11:0] OFS_BUS_INTERRUPT_CONTROL = 12'h008;
  localparam logic [11:0] OFS_OUTCOME_STATUS        = 12'h010;

  // ==========================================================================
  // Event flag positions in otg_event_flags.
  localparam int BIT_DEBOUNCE_FINISHED    = 19;
  localparam int BIT_A_SIDE_WAIT_TIMEOUT  = 18;
  localparam int BIT_NEGOTIATION_SEEN     = 17;
  localparam int BIT_NEGOTIATION_FINISHED = 9;
  localparam int BIT_SESSION_REQ_FINISHED = 8;
  localparam int BIT_SESSION_OVER         = 2;

  // Bits of otg_event_flags that hold a flag; all others read as zero.
  localparam logic [31:0] FLAG_MASK = 32'h000e_0304;

  // ==========================================================================
  // Field positions in bus_interrupt_control.
  localparam int BIT_PERIODIC_TX_THRESHOLD = 8;
  localparam int BIT_TX_THRESHOLD          = 7;
  localparam int BIT_GLOBAL_IRQ_ENABLE     = 0;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0181;

  // Field positions in outcome_status (read only).
  localparam int BIT_NEGOTIATION_SUCCESS     = 1;
  localparam int BIT_SESSION_REQUEST_SUCCESS = 0;

  // ==========================================================================
  // Reset values.
  localparam logic [31:0] RST_OTG_EVENT_FLAGS       = 32'h0000_0000;
  localparam logic [31:0] RST_BUS_INTERRUPT_CONTROL = 32'h0000_0000;

endpackage

/* File: core/uoeb_regs.sv */
// OTG event flag register and bus interrupt control register behind APB.
// Assumes event pulses and FIFO levels come from logic on ref_clk, and
// the VBUS comparator level arrives asynchronously from the analog side.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns

module uoeb_regs (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // APB slave port.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller mode and OTG event sources.
  input  wire logic        host_mode,
  input  wire logic        debounce_done_pulse,
  input  wire logic        a_wait_timeout_pulse,
  input  wire logic        negotiation_request_pulse,
  input  wire logic        negotiation_done_pulse,
  input  wire logic        session_request_done_pulse,
  input  wire logic        vbus_above_b_session_valid,
  input  wire logic        negotiation_success_status,
  input  wire logic        session_request_success_status,
  // Transmit FIFO levels.
  input  wire logic        ptx_fifo_half_empty,
  input  wire logic        ptx_fifo_empty,
  input  wire logic        tx_fifo_half_empty,
  input  wire logic        tx_fifo_empty,
  // Other interrupt sources of the controller.
  input  wire logic        core_irq_sources,
  // Events and interrupt out.
  output logic             periodic_tx_empty_event,
  output logic             in_endpoint_tx_empty_event,
  output logic             nonperiodic_tx_empty_event,
  output logic             usb_irq
);

  // ==========================================================================
  // Declarations.
  logic [31:0] otg_event_flags_r;
  logic [31:0] otg_event_flags_nxt;
  logic [31:0] bus_interrupt_control_r;
  logic [31:0] event_set;
  logic [31:0] clear_req;
  logic [31:0] read_mux;
  logic        vbus_sync1_r;
  logic        vbus_sync2_r;
  logic        vbus_prev_r;
  logic        session_drop;
  logic        setup_phase;
  logic        access_done;
  logic        addr_known;
  logic        global_irq_enable;
  logic        periodic_tx_threshold_sel;
  logic        tx_threshold_sel;

  // ==========================================================================
  // APB decode.

  // A setup cycle is the first cycle of a selected transfer.
  assign setup_phase = psel && !penable;
  // The access completes at the edge where pready is seen high.
  assign access_done = psel && penable && pready;
  // Only the three mapped words answer without an error.
  assign addr_known = (paddr == uoeb_pkg::OFS_OTG_EVENT_FLAGS)
                   || (paddr == uoeb_pkg::OFS_BUS_INTERRUPT_CONTROL)
                   || (paddr == uoeb_pkg::OFS_OUTCOME_STATUS);

  // Read data mux; reserved bits read as zero.
  always_comb begin
    read_mux = 32'h0000_0000;
    case (paddr)
      uoeb_pkg::OFS_OTG_EVENT_FLAGS: begin
        read_mux = otg_event_flags_r;
      end
      uoeb_pkg::OFS_BUS_INTERRUPT_CONTROL: begin
        read_mux = bus_interrupt_control_r;
      end
      uoeb_pkg::OFS_OUTCOME_STATUS: begin
        read_mux[uoeb_pkg::BIT_NEGOTIATION_SUCCESS]     = negotiation_success_status;
        read_mux[uoeb_pkg::BIT_SESSION_REQUEST_SUCCESS] = session_request_success_status;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  // The slave answers in the first access cycle, one wait-free transfer.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !addr_known;
      if (setup_phase && !pwrite) begin
        prdata <= read_mux;
      end
    end
  end

  // ==========================================================================
  // VBUS level crossing and drop detection.

  // Two flip-flops bring the comparator level onto ref_clk.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vbus_sync1_r <= 1'b0;
      vbus_sync2_r <= 1'b0;
      vbus_prev_r  <= 1'b0;
    end else begin
      vbus_sync1_r <= vbus_above_b_session_valid;
      vbus_sync2_r <= vbus_sync1_r;
      vbus_prev_r  <= vbus_sync2_r;
    end
  end

  // A fall of the synchronised level marks the end of the session.
  assign session_drop = vbus_prev_r && !vbus_sync2_r;

  // ==========================================================================
  // Event flag register.

  // Gather each hardware event at its flag position.
  always_comb begin
    event_set = 32'h0000_0000;
    event_set[uoeb_pkg::BIT_DEBOUNCE_FINISHED]    = debounce_done_pulse && host_mode;
    event_set[uoeb_pkg::BIT_A_SIDE_WAIT_TIMEOUT]  = a_wait_timeout_pulse;
    event_set[uoeb_pkg::BIT_NEGOTIATION_SEEN]     = negotiation_request_pulse;
    event_set[uoeb_pkg::BIT_NEGOTIATION_FINISHED] = negotiation_done_pulse;
    event_set[uoeb_pkg::BIT_SESSION_REQ_FINISHED] = session_request_done_pulse;
    event_set[uoeb_pkg::BIT_SESSION_OVER]         = session_drop;
  end

  // Write-one-to-clear request for the completing write to the flag word.
  assign clear_req = (access_done && pwrite && (paddr == uoeb_pkg::OFS_OTG_EVENT_FLAGS))
                   ? pwdata : 32'h0000_0000;

  // Each implemented bit: a set in the clearing cycle wins over the clear.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_flag
      if (uoeb_pkg::FLAG_MASK[gi]) begin : g_live
        assign otg_event_flags_nxt[gi] = event_set[gi]
                                      || (otg_event_flags_r[gi] && !clear_req[gi]);
      end else begin : g_zero
        assign otg_event_flags_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  // Flag storage.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      otg_event_flags_r <= uoeb_pkg::RST_OTG_EVENT_FLAGS;
    end else begin
      otg_event_flags_r <= otg_event_flags_nxt;
    end
  end

  // ==========================================================================
  // Bus interrupt control register.

  // Plain read-write fields; reserved bits stay at zero.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_interrupt_control_r <= uoeb_pkg::RST_BUS_INTERRUPT_CONTROL;
    end else if (access_done && pwrite
                 && (paddr == uoeb_pkg::OFS_BUS_INTERRUPT_CONTROL)) begin
      bus_interrupt_control_r <= pwdata & uoeb_pkg::CTRL_MASK;
    end
  end

  assign global_irq_enable         = bus_interrupt_control_r[uoeb_pkg::BIT_GLOBAL_IRQ_ENABLE];
  assign periodic_tx_threshold_sel = bus_interrupt_control_r[uoeb_pkg::BIT_PERIODIC_TX_THRESHOLD];
  assign tx_threshold_sel          = bus_interrupt_control_r[uoeb_pkg::BIT_TX_THRESHOLD];

  // ==========================================================================
  // FIFO empty events and the interrupt output.

  // Threshold selects the FIFO level; the mode selects which event fires.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      periodic_tx_empty_event    <= 1'b0;
      in_endpoint_tx_empty_event <= 1'b0;
      nonperiodic_tx_empty_event <= 1'b0;
    end else begin
      periodic_tx_empty_event    <= host_mode
        && (periodic_tx_threshold_sel ? ptx_fifo_empty : ptx_fifo_half_empty);
      in_endpoint_tx_empty_event <= !host_mode
        && (tx_threshold_sel ? tx_fifo_empty : tx_fifo_half_empty);
      nonperiodic_tx_empty_event <= host_mode
        && (tx_threshold_sel ? tx_fifo_empty : tx_fifo_half_empty);
    end
  end

  // Any pending flag or other source raises the interrupt, if enabled.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      usb_irq <= 1'b0;
    end else begin
      usb_irq <= global_irq_enable
              && ((|otg_event_flags_r) || core_irq_sources);
    end
  end

  // ==========================================================================
  // Assertions.

  a_debounce_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    debounce_done_pulse && host_mode |=> otg_event_flags_r[uoeb_pkg::BIT_DEBOUNCE_FINISHED])
    else $error("Debounce flag not set after host-mode debounce.");

  a_debounce_device_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    !otg_event_flags_r[uoeb_pkg::BIT_DEBOUNCE_FINISHED] && !(debounce_done_pulse && host_mode)
    |=> !otg_event_flags_r[uoeb_pkg::BIT_DEBOUNCE_FINISHED])
    else $error("Debounce flag set without a host-mode cause.");

  a_timeout_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    a_wait_timeout_pulse |=> otg_event_flags_r[uoeb_pkg::BIT_A_SIDE_WAIT_TIMEOUT])
    else $error("A-side timeout flag not set.");

  a_request_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    negotiation_request_pulse |=> otg_event_flags_r[uoeb_pkg::BIT_NEGOTIATION_SEEN])
    else $error("Negotiation request flag not set.");

  a_neg_end_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    negotiation_done_pulse |=> otg_event_flags_r[uoeb_pkg::BIT_NEGOTIATION_FINISHED])
    else $error("Negotiation finished flag not set.");

  a_srp_end_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    session_request_done_pulse |=> otg_event_flags_r[uoeb_pkg::BIT_SESSION_REQ_FINISHED])
    else $error("Session request finished flag not set.");

  a_outcome_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    setup_phase && !pwrite && (paddr == uoeb_pkg::OFS_OUTCOME_STATUS)
    |=> (prdata[uoeb_pkg::BIT_NEGOTIATION_SUCCESS] == $past(negotiation_success_status))
        && (prdata[uoeb_pkg::BIT_SESSION_REQUEST_SUCCESS]
            == $past(session_request_success_status)))
    else $error("Outcome status read does not show the status inputs.");

  a_vbus_drop_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(vbus_sync2_r) |=> otg_event_flags_r[uoeb_pkg::BIT_SESSION_OVER])
    else $error("Session over flag not set after VBUS drop.");

  a_session_over_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    !otg_event_flags_r[uoeb_pkg::BIT_SESSION_OVER] && !session_drop
    |=> !otg_event_flags_r[uoeb_pkg::BIT_SESSION_OVER])
    else $error("Session over flag set without a VBUS drop.");

  a_periodic_half: assert property (@(posedge ref_clk) disable iff (!nrst)
    host_mode && !periodic_tx_threshold_sel && ptx_fifo_half_empty |=> periodic_tx_empty_event)
    else $error("Periodic empty event missed at half empty.");

  a_periodic_device_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    !host_mode |=> !periodic_tx_empty_event)
    else $error("Periodic empty event fired in device mode.");

  a_in_ep_full: assert property (@(posedge ref_clk) disable iff (!nrst)
    !host_mode && tx_threshold_sel && tx_fifo_empty |=> in_endpoint_tx_empty_event)
    else $error("IN endpoint empty event missed at full empty.");

  a_in_ep_host_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    host_mode |=> !in_endpoint_tx_empty_event)
    else $error("IN endpoint empty event fired in host mode.");

  a_np_half: assert property (@(posedge ref_clk) disable iff (!nrst)
    host_mode && !tx_threshold_sel && tx_fifo_half_empty |=> nonperiodic_tx_empty_event)
    else $error("Non-periodic empty event missed at half empty.");

  a_np_device_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    !host_mode |=> !nonperiodic_tx_empty_event)
    else $error("Non-periodic empty event fired in device mode.");

  a_irq_raised: assert property (@(posedge ref_clk) disable iff (!nrst)
    global_irq_enable && ((|otg_event_flags_r) || core_irq_sources) |=> usb_irq)
    else $error("Enabled interrupt cause did not raise the interrupt.");

  a_ctrl_write_lands: assert property (@(posedge ref_clk) disable iff (!nrst)
    access_done && pwrite && (paddr == uoeb_pkg::OFS_BUS_INTERRUPT_CONTROL)
    |=> bus_interrupt_control_r == ($past(pwdata) & uoeb_pkg::CTRL_MASK))
    else $error("Control write did not land in its fields.");

  a_ctrl_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (bus_interrupt_control_r & ~uoeb_pkg::CTRL_MASK) == 32'h0000_0000)
    else $error("Reserved control bit is set.");

  a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    (event_set & clear_req) != 32'h0000_0000
    |=> (otg_event_flags_r & $past(event_set)) == $past(event_set))
    else $error("Clearing write won over a new event.");

  a_unwritten_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
    (otg_event_flags_r & ~clear_req) != 32'h0000_0000
    |=> (otg_event_flags_r & $past(otg_event_flags_r) & ~$past(clear_req))
        == ($past(otg_event_flags_r) & ~$past(clear_req)))
    else $error("Flag lost although its bit was written with zero.");

  a_flag_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (otg_event_flags_r & ~uoeb_pkg::FLAG_MASK) == 32'h0000_0000)
    else $error("Reserved flag bit is set.");

  a_periodic_threshold: assert property (@(posedge ref_clk) disable iff (!nrst)
    host_mode && periodic_tx_threshold_sel && !ptx_fifo_empty |=> !periodic_tx_empty_event)
    else $error("Periodic empty event fired before full empty.");

  a_in_ep_threshold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !host_mode && !tx_threshold_sel && tx_fifo_half_empty |=> in_endpoint_tx_empty_event)
    else $error("IN endpoint empty event missed at half empty.");

  a_np_threshold: assert property (@(posedge ref_clk) disable iff (!nrst)
    host_mode ##1 host_mode && tx_threshold_sel && tx_fifo_empty |=> nonperiodic_tx_empty_event)
    else $error("Non-periodic empty event missed at full empty.");

  a_irq_gated: assert property (@(posedge ref_clk) disable iff (!nrst)
    !global_irq_enable |=> !usb_irq)
    else $error("Interrupt raised while globally disabled.");

  a_flag_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    otg_event_flags_r[uoeb_pkg::BIT_A_SIDE_WAIT_TIMEOUT]
    && !clear_req[uoeb_pkg::BIT_A_SIDE_WAIT_TIMEOUT]
    |=> otg_event_flags_r[uoeb_pkg::BIT_A_SIDE_WAIT_TIMEOUT] [*1])
    else $error("Flag lost without a write of one.");

  a_flag_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
    clear_req[uoeb_pkg::BIT_NEGOTIATION_SEEN] && !negotiation_request_pulse
    |=> !otg_event_flags_r[uoeb_pkg::BIT_NEGOTIATION_SEEN])
    else $error("Flag not cleared by a write of one.");

  a_bad_addr_error: assert property (@(posedge ref_clk) disable iff (!nrst)
    setup_phase && !addr_known |=> pready && pslverr)
    else $error("Unmapped access answered without an error.");

  a_ready_one_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
    pready |=> !pready)
    else $error("Ready stood for more than one cycle.");

  a_apb_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
    psel && !penable ##1 psel && penable |-> pready)
    else $error("APB access not answered in its first access cycle.");

endmodule

/* File: verification/uoeb_otg_peer.sv */
// Behavioural model of the OTG state machines that feed the event inputs.
// Assumes the bench raises one request bit for one ref_clk cycle per event.
`timescale 1ns/1ns

module uoeb_otg_peer (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Requests: debounce, timeout, negotiation seen, negotiation end, session request end.
  input  wire logic [4:0] ev_req,
  // Single-cycle event pulses towards the block.
  output logic      [4:0] ev_pulse
);
  // ==========================================================================
  // Pulse generation
  // Each request leaves as a one-cycle pulse, as the state machines emit them.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ev_pulse <= 5'h00;
    end else begin
      ev_pulse <= ev_req;
    end
  end
endmodule

/* File: verification/usb_otg_event_flags_and_bus_ctrl_tb.sv */
// Self-checking bench for the OTG event flag and bus control registers.
// Assumes the APB slave answers on its own; every wait is bounded.
`timescale 1ns/1ns

module usb_otg_event_flags_and_bus_ctrl_tb;
  localparam logic [11:0] FL = uoeb_pkg::OFS_OTG_EVENT_FLAGS;
  localparam logic [11:0] CT = uoeb_pkg::OFS_BUS_INTERRUPT_CONTROL;
  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic        host_mode, vbus_ok, neg_ok, ses_ok, core_irq, usb_irq;
  logic        ptx_half, ptx_empty, tx_half, tx_empty, pte, ite, nte;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [4:0]  ev_req, ev_pulse;
  int          fb[5];
  int          n_mismatch, compares;

  // ==========================================================================
  // Clock, partner and design
  // The clock toggles every 5 ns, a period of 10 ns.
  always #5 ref_clk = ~ref_clk;
  uoeb_otg_peer i_peer (.ref_clk(ref_clk), .nrst(nrst), .ev_req(ev_req), .ev_pulse(ev_pulse));
  uoeb_regs i_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_mode(host_mode), .debounce_done_pulse(ev_pulse[4]),
    .a_wait_timeout_pulse(ev_pulse[3]), .negotiation_request_pulse(ev_pulse[2]),
    .negotiation_done_pulse(ev_pulse[1]), .session_request_done_pulse(ev_pulse[0]),
    .vbus_above_b_session_valid(vbus_ok), .negotiation_success_status(neg_ok),
    .session_request_success_status(ses_ok), .ptx_fifo_half_empty(ptx_half),
    .ptx_fifo_empty(ptx_empty), .tx_fifo_half_empty(tx_half), .tx_fifo_empty(tx_empty),
    .core_irq_sources(core_irq), .periodic_tx_empty_event(pte),
    .in_endpoint_tx_empty_event(ite), .nonperiodic_tx_empty_event(nte), .usb_irq(usb_irq));

  // ==========================================================================
  // Tasks
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (k >= 16 && pready !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Reads a register and compares it with the expected word.
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "register read");
  endtask

  // Sends one event request through the partner and lets the flag land.
  task automatic fire(input logic [4:0] q);
    ev_req <= q;
    @(posedge ref_clk);
    ev_req <= 5'h00;
    repeat (3) @(posedge ref_clk);
  endtask

  // Works out the three FIFO events from the stimulus word.
  function automatic logic [31:0] exp_fifo(input logic [31:0] v);
    logic p, t;
    p = v[uoeb_pkg::BIT_PERIODIC_TX_THRESHOLD] ? v[3] : (v[2] | v[3]);
    t = v[uoeb_pkg::BIT_TX_THRESHOLD] ? v[5] : (v[4] | v[5]);
    return {29'h0, v[10] & p, !v[10] & t, v[10] & t};
  endfunction

  // ==========================================================================
  // Main sequence
  // Drives every input at time zero, then runs the tests in turn.
  initial begin
    {ref_clk, nrst, psel, penable, pwrite, host_mode, neg_ok, ses_ok, core_irq} = '0;
    {ptx_half, ptx_empty, tx_half, tx_empty} = '0;
    {paddr, pwdata, ev_req, n_mismatch, compares} = '0;
    vbus_ok = 1'b1;
    fb = '{uoeb_pkg::BIT_DEBOUNCE_FINISHED, uoeb_pkg::BIT_A_SIDE_WAIT_TIMEOUT,
           uoeb_pkg::BIT_NEGOTIATION_SEEN, uoeb_pkg::BIT_NEGOTIATION_FINISHED,
           uoeb_pkg::BIT_SESSION_REQ_FINISHED};
    r = $urandom(32'hfc0c);
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rdchk(FL, uoeb_pkg::RST_OTG_EVENT_FLAGS);
    rdchk(CT, uoeb_pkg::RST_BUS_INTERRUPT_CONTROL);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read data");
    $display("test reset done");
    host_mode <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      fire(5'h10 >> i);
      rdchk(FL, 32'h1 << fb[i]);
      apb(1'b1, FL, ~(32'h1 << fb[i]));
      rdchk(FL, 32'h1 << fb[i]);
      apb(1'b1, FL, 32'h1 << fb[i]);
      rdchk(FL, 32'h0);
    end
    // The event pulse meets the clearing write on the same edge; the set must win.
    fork
      fire(5'h04);
      apb(1'b1, FL, 32'h1 << fb[2]);
    join
    rdchk(FL, 32'h1 << fb[2]);
    apb(1'b1, FL, 32'h1 << fb[2]);
    host_mode <= 1'b0;
    fire(5'h10);
    rdchk(FL, 32'h0);
    vbus_ok <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rdchk(FL, 32'h1 << uoeb_pkg::BIT_SESSION_OVER);
    $display("test flags done");
    apb(1'b1, CT, 32'hffff_ffff);
    rdchk(CT, uoeb_pkg::CTRL_MASK);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, usb_irq}, 32'h1, "irq enabled");
    apb(1'b1, CT, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, usb_irq}, 32'h0, "irq blocked");
    vbus_ok <= 1'b1;
    apb(1'b1, FL, 32'h4);
    $display("test irq done");
    // A reset in mid-run must drop a pending flag and the enable.
    apb(1'b1, CT, uoeb_pkg::CTRL_MASK);
    fire(5'h08);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk({31'h0, usb_irq}, 32'h0, "irq after reset");
    rdchk(FL, uoeb_pkg::RST_OTG_EVENT_FLAGS);
    rdchk(CT, uoeb_pkg::RST_BUS_INTERRUPT_CONTROL);
    $display("test mid-run reset done");
    for (int n = 0; n < 32; n++) begin
      r = $urandom;
      host_mode <= r[10];
      core_irq  <= r[1];
      ptx_half  <= r[2] | r[3];
      ptx_empty <= r[3];
      tx_half   <= r[4] | r[5];
      tx_empty  <= r[5];
      neg_ok    <= r[11];
      ses_ok    <= r[12];
      apb(1'b1, CT, r);
      repeat (2) @(posedge ref_clk);
      chk({29'h0, pte, ite, nte}, exp_fifo(r), "fifo events");
      chk({31'h0, usb_irq}, {31'h0, r[0] & r[1]}, "irq gate");
      rdchk(uoeb_pkg::OFS_OUTCOME_STATUS, {30'h0, r[11], r[12]});
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule
